// file: src/ppb_ctrl.sv
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/10ps
// Operation
// - four 4-bit fields set write and read strobe assert and negate delays
// - delay code n lasts n+1 half system cycles
// - port width field: 10 is a 16-bit port, 01 an 8-bit port
// - wait state field sets cycles inserted before the access terminates
// - zero wait states give a one-clock strobe access
// - one wait state gives a two-clock strobe access
// - all 64 wait codes work, 111111 gives 64 cycles
// - with select logic off the chip select stays high
// - one pull-up enable per data pin when used as gpio input
// - byte order bit: 1 little endian, 0 big endian
// - two bits hand upper and lower data bytes to gpio
// - control-pin bit routes select, strobes, register-select to irq lines
// - gpio output pins drive the last written output value
// - per-pin direction: 1 output, 0 input
// - input register reads the current data pin levels
// - register-select tells the panel command or data
// - a word on a 16-bit port takes two half-word cycles
module ppb_ctrl
  import ppb_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [15:0] panel_data_pins_in,
  output logic [15:0] panel_data_pins_out,
  output logic [15:0] panel_data_pins_oe_n,
  output logic [15:0] panel_data_pins_pull_up,
  input ppb_ctl_t ctl_pins_in,
  output ppb_ctl_t ctl_pins_out,
  output logic [3:0] ctl_pins_oe_n,
  output logic [5:0] ext_irq_lines
);

  // ==========
  // declarations
  // ==========
  ppb_ahb_t st_q;
  ppb_dphase_t dp_q;
  logic hreadyout_q;
  logic [31:0] hrdata_q;
  ppb_timing_t timing_q;
  logic [15:0] pull_q;
  logic [3:0] func_q;
  logic [15:0] gpio_out_q;
  logic [15:0] gpio_dir_q;
  logic [15:0] pin_in_bits_q;
  logic [15:0] pins_out_q;
  logic [15:0] pins_oe_n_q;
  logic [15:0] pins_pull_q;
  ppb_ctl_t ctl_out_q;
  logic [3:0] ctl_oe_n_q;
  logic [5:0] irq_q;
  logic accept;
  logic reg_wr;
  logic eng_start;
  logic eng_done;
  logic [31:0] eng_rdata;
  ppb_bus_t eng_bus;
  logic byte_order_little;
  logic lower_byte_gpio_sel;
  logic upper_byte_gpio_sel;
  logic control_pins_irq_sel;

  assign byte_order_little = func_q[0];
  assign lower_byte_gpio_sel = func_q[1];
  assign upper_byte_gpio_sel = func_q[2];
  assign control_pins_irq_sel = func_q[3];

  // ==========
  // register read decode
  // ==========
  // unmapped offsets read as zero; reserved bits are forced to zero
  function automatic logic [31:0] reg_read(input logic [7:0] ofs);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (ofs)
      OFS_TIMING: begin
        v = timing_q;
        v[31:25] = 7'h00;
      end
      OFS_PULL: v[15:0] = pull_q;
      OFS_FUNC: v[FUNC_IRQ_BIT:FUNC_LITTLE_BIT] = func_q;
      OFS_OUT: v[15:0] = gpio_out_q;
      OFS_DIR: v[15:0] = gpio_dir_q;
      OFS_IN: v[15:0] = pin_in_bits_q;
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // ==========
  // bus slave: address phase capture
  // ==========
  // hsize is not checked: only whole-word single transfers are used
  assign accept = hsel && htrans[1] && hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_q <= '0;
    end else if (accept) begin
      dp_q.valid <= 1'b1;
      dp_q.write <= hwrite;
      dp_q.panel <= haddr[PANEL_WIN_BIT];
      dp_q.ofs <= {haddr[7:2], 2'b00};
    end else if (hreadyout_q) begin
      dp_q.valid <= 1'b0;
    end
  end

  // register writes complete with no wait state
  assign reg_wr = dp_q.valid && dp_q.write && !dp_q.panel && st_q == A_IDLE;

  // ==========
  // bus slave: transfer sequencing
  // ==========
  // register reads take one wait so that hrdata comes from a flop
  // and already reflects a write in the data phase just before
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= A_IDLE;
      hreadyout_q <= 1'b1;
    end else begin
      case (st_q)
        A_IDLE: begin
          if (accept && haddr[PANEL_WIN_BIT]) begin
            st_q <= A_PANEL_GO;
            hreadyout_q <= 1'b0;
          end else if (accept && !hwrite) begin
            st_q <= A_REG_RD;
            hreadyout_q <= 1'b0;
          end else begin
            hreadyout_q <= 1'b1;
          end
        end
        A_REG_RD: begin
          st_q <= A_IDLE;
          hreadyout_q <= 1'b1;
        end
        A_PANEL_GO: begin
          st_q <= A_PANEL_WAIT;
        end
        A_PANEL_WAIT: begin
          // the access ends only when the panel cycles have all run
          if (eng_done) begin
            st_q <= A_IDLE;
            hreadyout_q <= 1'b1;
          end
        end
        default: begin
          st_q <= A_IDLE;
          hreadyout_q <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (st_q == A_REG_RD) begin
      hrdata_q <= reg_read(dp_q.ofs);
    end else if (st_q == A_PANEL_WAIT && eng_done && !dp_q.write) begin
      hrdata_q <= eng_rdata;
    end
  end

  // hwdata is valid in the first data phase cycle, when the engine starts
  assign eng_start = (st_q == A_PANEL_GO);

  // ==========
  // configuration registers
  // ==========
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timing_q <= TIMING_RST;
    end else if (reg_wr && dp_q.ofs == OFS_TIMING) begin
      timing_q <= hwdata;
      timing_q.rsvd <= 7'h00;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pull_q <= PIN_RST;
    end else if (reg_wr && dp_q.ofs == OFS_PULL) begin
      pull_q <= hwdata[15:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      func_q <= FUNC_RST[FUNC_IRQ_BIT:FUNC_LITTLE_BIT];
    end else if (reg_wr && dp_q.ofs == OFS_FUNC) begin
      func_q <= hwdata[FUNC_IRQ_BIT:FUNC_LITTLE_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gpio_out_q <= PIN_RST;
    end else if (reg_wr && dp_q.ofs == OFS_OUT) begin
      gpio_out_q <= hwdata[15:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gpio_dir_q <= PIN_RST;
    end else if (reg_wr && dp_q.ofs == OFS_DIR) begin
      gpio_dir_q <= hwdata[15:0];
    end
  end

  // pins are synchronous to hclk, so one sampling stage is enough
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_in_bits_q <= PIN_RST;
    end else begin
      pin_in_bits_q <= panel_data_pins_in;
    end
  end

  // ==========
  // panel cycle engine
  // ==========
  ppb_cycle u_cycle (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(eng_start),
    .wr_op(dp_q.write),
    .wdata(hwdata),
    .cfg(timing_q),
    .little(byte_order_little),
    .din(panel_data_pins_in),
    .bus(eng_bus),
    .rdata(eng_rdata),
    .done(eng_done)
  );

  // ==========
  // data pin multiplexing
  // ==========
  // each byte lane is either gpio or panel data, chosen separately
  generate
    for (genvar i = 0; i < 16; i++) begin : g_pin
      logic lane_gpio;
      assign lane_gpio = (i >= 8) ? upper_byte_gpio_sel : lower_byte_gpio_sel;

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          pins_out_q[i] <= 1'b0;
          pins_oe_n_q[i] <= 1'b1;
          pins_pull_q[i] <= 1'b0;
        end else if (lane_gpio) begin
          pins_out_q[i] <= gpio_out_q[i];
          pins_oe_n_q[i] <= ~gpio_dir_q[i];
          pins_pull_q[i] <= pull_q[i] & ~gpio_dir_q[i];
        end else begin
          pins_out_q[i] <= eng_bus.dout[i];
          pins_oe_n_q[i] <= ~eng_bus.drive;
          pins_pull_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // ==========
  // control pins and external interrupt routing
  // ==========
  // when routed to the irq port the control pins become inputs;
  // the cycle engine keeps running but its strobes stay off the pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_out_q <= 4'b1110;
      ctl_oe_n_q <= 4'b0000;
    end else if (control_pins_irq_sel) begin
      ctl_out_q <= 4'b1110;
      ctl_oe_n_q <= 4'b1111;
    end else begin
      ctl_out_q <= eng_bus.ctl;
      ctl_oe_n_q <= 4'b0000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_q <= 6'h00;
    end else begin
      irq_q <= 6'h00;
      if (control_pins_irq_sel) begin
        irq_q[IRQ_CS_LINE] <= ctl_pins_in.panel_select_n;
        irq_q[IRQ_RD_LINE] <= ctl_pins_in.panel_read_strobe_n;
        irq_q[IRQ_WR_LINE] <= ctl_pins_in.panel_write_strobe_n;
        irq_q[IRQ_RS_LINE] <= ctl_pins_in.command_data_select;
      end
    end
  end

  // ==========
  // outputs
  // ==========
  assign hreadyout = hreadyout_q;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign panel_data_pins_out = pins_out_q;
  assign panel_data_pins_oe_n = pins_oe_n_q;
  assign panel_data_pins_pull_up = pins_pull_q;
  assign ctl_pins_out = ctl_out_q;
  assign ctl_pins_oe_n = ctl_oe_n_q;
  assign ext_irq_lines = irq_q;

endmodule

// file: src/ppb_pkg.sv
package ppb_pkg;

  // ==========================================================
  // register map (byte offsets within the register window)
  // ==========================================================
  localparam logic [7:0] OFS_TIMING = 8'h00;
  localparam logic [7:0] OFS_PULL = 8'h0c;
  localparam logic [7:0] OFS_FUNC = 8'h10;
  localparam logic [7:0] OFS_OUT = 8'h14;
  localparam logic [7:0] OFS_DIR = 8'h18;
  localparam logic [7:0] OFS_IN = 8'h1c;

  // address bit that selects the panel window instead of the registers
  localparam int PANEL_WIN_BIT = 20;

  // ==========================================================
  // field positions and codes
  // ==========================================================
  localparam logic [1:0] PW_16 = 2'b10;
  localparam logic [1:0] PW_8 = 2'b01;
  localparam int FUNC_LITTLE_BIT = 16;
  localparam int FUNC_LOWER_BIT = 17;
  localparam int FUNC_UPPER_BIT = 18;
  localparam int FUNC_IRQ_BIT = 19;
  localparam int IRQ_CS_LINE = 5;
  localparam int IRQ_RD_LINE = 4;
  localparam int IRQ_WR_LINE = 2;
  localparam int IRQ_RS_LINE = 1;

  // ==========================================================
  // reset values
  // ==========================================================
  localparam logic [31:0] TIMING_RST = 32'h0002_0000;
  localparam logic [31:0] FUNC_RST = 32'h0000_0000;
  localparam logic [15:0] PIN_RST = 16'h0000;

  // ==========================================================
  // timing: strobe delays count in half system cycles
  // ==========================================================
  localparam int HALF_PER_CYCLE = 2;

  // least time rounds up: (code+1) halves -> ceil((code+1)/2) cycles
  function automatic logic [3:0] half_to_cyc(input logic [3:0] code);
    logic [4:0] s;
    s = {1'b0, code} + 5'(HALF_PER_CYCLE);
    return s[4:1];
  endfunction

  // ==========================================================
  // types
  // ==========================================================
  typedef struct packed {
    logic [6:0] rsvd;
    logic select_logic_on;
    logic [5:0] wait_state_count;
    logic [1:0] port_width_sel;
    logic [3:0] read_negate_delay;
    logic [3:0] read_assert_delay;
    logic [3:0] write_negate_delay;
    logic [3:0] write_assert_delay;
  } ppb_timing_t;

  typedef struct packed {
    logic panel_select_n;
    logic panel_read_strobe_n;
    logic panel_write_strobe_n;
    logic command_data_select;
  } ppb_ctl_t;

  typedef struct packed {
    ppb_ctl_t ctl;
    logic drive;
    logic [15:0] dout;
  } ppb_bus_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic panel;
    logic [7:0] ofs;
  } ppb_dphase_t;

  typedef enum {P_IDLE, P_SETUP, P_STROBE, P_HOLD} ppb_phase_t;
  typedef enum {A_IDLE, A_REG_RD, A_PANEL_GO, A_PANEL_WAIT} ppb_ahb_t;

endpackage

// file: src/ppb_cycle.sv
`timescale 1ns/10ps
module ppb_cycle
  import ppb_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start,
  input wire logic wr_op,
  input wire logic [31:0] wdata,
  input ppb_timing_t cfg,
  input wire logic little,
  input wire logic [15:0] din,
  output ppb_bus_t bus,
  output logic [31:0] rdata,
  output logic done
);

  ppb_phase_t ph_q;
  logic [6:0] cnt_q;
  logic [1:0] beat_q;
  logic [1:0] last_q;
  logic wr_q;
  logic [31:0] wdata_q;
  logic [31:0] rdata_q;
  logic done_q;
  logic port8;
  logic [1:0] lane;
  logic [6:0] setup_len;
  logic [6:0] hold_len;

  assign port8 = (cfg.port_width_sel == PW_8);
  // big endian sends the most significant part first
  assign lane = little ? beat_q : 2'(last_q - beat_q);
  assign setup_len = 7'(wr_q ? half_to_cyc(cfg.write_assert_delay)
                             : half_to_cyc(cfg.read_assert_delay));
  assign hold_len = 7'(wr_q ? half_to_cyc(cfg.write_negate_delay)
                            : half_to_cyc(cfg.read_negate_delay));

  // ==========
  // phase sequencer
  // ==========
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_q <= P_IDLE;
      cnt_q <= 7'h00;
      beat_q <= 2'h0;
      last_q <= 2'h0;
      wr_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (ph_q)
        P_IDLE: begin
          if (start) begin
            ph_q <= P_SETUP;
            // setup length is decided with wr_op since wr_q is not loaded yet
            cnt_q <= 7'(wr_op ? half_to_cyc(cfg.write_assert_delay)
                              : half_to_cyc(cfg.read_assert_delay)) - 7'h01;
            beat_q <= 2'h0;
            last_q <= port8 ? 2'h3 : 2'h1;
            wr_q <= wr_op;
          end
        end
        P_SETUP: begin
          if (cnt_q == 7'h00) begin
            ph_q <= P_STROBE;
            cnt_q <= {1'b0, cfg.wait_state_count};
          end else begin
            cnt_q <= cnt_q - 7'h01;
          end
        end
        P_STROBE: begin
          if (cnt_q == 7'h00) begin
            ph_q <= P_HOLD;
            cnt_q <= hold_len - 7'h01;
          end else begin
            cnt_q <= cnt_q - 7'h01;
          end
        end
        P_HOLD: begin
          if (cnt_q != 7'h00) begin
            cnt_q <= cnt_q - 7'h01;
          end else if (beat_q == last_q) begin
            ph_q <= P_IDLE;
            done_q <= 1'b1;
          end else begin
            // next half-word or byte, only while the strobe is negated
            beat_q <= beat_q + 2'h1;
            ph_q <= P_SETUP;
            cnt_q <= setup_len - 7'h01;
          end
        end
        default: ph_q <= P_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdata_q <= 32'h0000_0000;
    end else if (start && ph_q == P_IDLE) begin
      wdata_q <= wdata;
    end
  end

  // pins lag the engine by a flop: the first hold cycle is the last low one there
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (ph_q == P_HOLD && cnt_q == hold_len - 7'h01 && !wr_q) begin
      if (port8) begin
        rdata_q[{lane, 3'b000} +: 8] <= din[15:8];
      end else begin
        rdata_q[{lane[0], 4'b0000} +: 16] <= din;
      end
    end
  end

  // ==========
  // pin-facing values
  // ==========
  assign bus.ctl.panel_select_n = ~((ph_q != P_IDLE) & cfg.select_logic_on);
  assign bus.ctl.panel_read_strobe_n = ~(ph_q == P_STROBE && !wr_q);
  assign bus.ctl.panel_write_strobe_n = ~(ph_q == P_STROBE && wr_q);
  assign bus.ctl.command_data_select = beat_q[0];
  assign bus.drive = (ph_q != P_IDLE) && wr_q;
  assign bus.dout = port8 ? {wdata_q[{lane, 3'b000} +: 8], 8'h00}
                          : wdata_q[{lane[0], 4'b0000} +: 16];
  assign rdata = rdata_q;
  assign done = done_q;

endmodule

// file: testbench/ppb_ctrl_properties.sv
`timescale 1ns/10ps
module ppb_ctrl_properties
  import ppb_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [15:0] panel_data_pins_out,
  input wire logic [15:0] panel_data_pins_oe_n,
  input wire logic [15:0] panel_data_pins_pull_up,
  input ppb_ctl_t ctl_pins_in,
  input ppb_ctl_t ctl_pins_out,
  input wire logic [3:0] ctl_pins_oe_n,
  input wire logic [5:0] ext_irq_lines
);
  // ==========
  // shadow of the register writes seen on the bus
  // ==========
  logic ap_v_q, ap_wr_q, wr_op_q;
  logic [7:0] ap_ofs_q;
  logic [31:0] tim_q, fn_q, do_q, dir_q, pu_q;
  logic [1:0] settle_q;
  logic [6:0] lo_q, hi_q;
  wire logic strobe_lo = !ctl_pins_out.panel_write_strobe_n || !ctl_pins_out.panel_read_strobe_n;
  wire logic [15:0] lane = {{8{fn_q[FUNC_UPPER_BIT]}}, {8{fn_q[FUNC_LOWER_BIT]}}};
  wire logic [4:0] hold_c = wr_op_q ? ({1'b0, tim_q[7:4]} + 5'd2) >> 1
    : ({1'b0, tim_q[15:12]} + 5'd2) >> 1;
  wire logic [4:0] setup_c = wr_op_q ? ({1'b0, tim_q[3:0]} + 5'd2) >> 1
    : ({1'b0, tim_q[11:8]} + 5'd2) >> 1;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_v_q <= 1'b0;
    end else if (hready) begin
      ap_v_q <= hsel && htrans[1] && !haddr[PANEL_WIN_BIT];
    end
  end

  always_ff @(posedge hclk) begin
    if (hready) begin
      ap_wr_q <= hwrite;
      ap_ofs_q <= haddr[7:0];
    end
  end

  // settle_q lets registered pin outputs catch up after a register write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tim_q <= TIMING_RST;
      fn_q <= FUNC_RST;
      do_q <= 32'h0;
      dir_q <= 32'h0;
      pu_q <= 32'h0;
      settle_q <= 2'h0;
    end else if (ap_v_q && ap_wr_q && hready) begin
      settle_q <= 2'h0;
      case (ap_ofs_q)
        OFS_TIMING: tim_q <= hwdata;
        OFS_PULL: pu_q <= hwdata;
        OFS_FUNC: fn_q <= hwdata;
        OFS_OUT: do_q <= hwdata;
        OFS_DIR: dir_q <= hwdata;
        default: ;
      endcase
    end else if (settle_q != 2'h3) begin
      settle_q <= settle_q + 2'h1;
    end
  end

  // cycle counters of strobe low time and of the gap since the last strobe
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lo_q <= 7'h0;
      hi_q <= 7'h0;
      wr_op_q <= 1'b0;
    end else begin
      lo_q <= strobe_lo ? lo_q + 7'h1 : 7'h0;
      hi_q <= strobe_lo ? 7'h0 : (hi_q == 7'h7f ? hi_q : hi_q + 7'h1);
      if (!ctl_pins_out.panel_write_strobe_n) begin
        wr_op_q <= 1'b1;
      end else if (!ctl_pins_out.panel_read_strobe_n) begin
        wr_op_q <= 1'b0;
      end
    end
  end

  // ==========
  // properties
  // ==========
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_begin;
    strobe_lo && !$past(strobe_lo);
  endsequence
  sequence s_end;
    !strobe_lo && $past(strobe_lo);
  endsequence

  property p_width;
    s_end |-> lo_q == {1'b0, tim_q[23:18]} + 7'h1;
  endproperty
  a_width: assert property (p_width) else $error("strobe width wrong");
  property p_setup;
    s_begin ##0 ctl_pins_out.command_data_select |-> hi_q == 7'(hold_c) + 7'(setup_c);
  endproperty
  a_setup: assert property (p_setup) else $error("beat gap wrong");
  property p_hold;
    $rose(ctl_pins_out.panel_select_n) && tim_q[24] |-> hi_q == 7'(hold_c);
  endproperty
  a_hold: assert property (p_hold) else $error("hold time wrong");
  property p_stable;
    !ctl_pins_out.panel_write_strobe_n && $past(!ctl_pins_out.panel_write_strobe_n)
      |-> $stable(panel_data_pins_out) && $stable(ctl_pins_out.command_data_select);
  endproperty
  a_stable: assert property (p_stable) else $error("data moved under strobe");
  property p_cs_off;
    settle_q == 2'h3 && !tim_q[24] |-> ctl_pins_out.panel_select_n;
  endproperty
  a_cs_off: assert property (p_cs_off) else $error("select low while off");
  property p_irq_on;
    settle_q == 2'h3 && fn_q[FUNC_IRQ_BIT] |-> ctl_pins_oe_n == 4'hf && ext_irq_lines ==
      {$past(ctl_pins_in[3:2]), 1'b0, $past(ctl_pins_in[1:0]), 1'b0};
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq routing wrong");
  property p_irq_off;
    settle_q == 2'h3 && !fn_q[FUNC_IRQ_BIT] |-> ctl_pins_oe_n == 4'h0 && ext_irq_lines == 6'h00;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("control pins not driven");
  property p_gpio;
    settle_q == 2'h3 |-> ((~panel_data_pins_oe_n & lane) == (dir_q[15:0] & lane))
      && ((panel_data_pins_out & lane & dir_q[15:0]) == (do_q[15:0] & lane & dir_q[15:0]));
  endproperty
  a_gpio: assert property (p_gpio) else $error("gpio pins wrong");
  property p_pull;
    settle_q == 2'h3 |-> panel_data_pins_pull_up == (pu_q[15:0] & lane & ~dir_q[15:0]);
  endproperty
  a_pull: assert property (p_pull) else $error("pull-up wrong");
endmodule

bind ppb_ctrl ppb_ctrl_properties u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .panel_data_pins_out(panel_data_pins_out), .panel_data_pins_oe_n(panel_data_pins_oe_n),
  .panel_data_pins_pull_up(panel_data_pins_pull_up), .ctl_pins_in(ctl_pins_in),
  .ctl_pins_out(ctl_pins_out), .ctl_pins_oe_n(ctl_pins_oe_n), .ext_irq_lines(ext_irq_lines));

// file: testbench/ppb_panel_model.sv
`timescale 1ns/10ps
module ppb_panel_model
  import ppb_pkg::*;
(
  input wire logic clr,
  input ppb_ctl_t ctl,
  input wire logic [15:0] data_lvl,
  input wire logic [63:0] rd_beats,
  output logic drv_en,
  output logic [15:0] drv_val,
  output logic [3:0][16:0] wr_log,
  output int wr_cnt
);
  // ==========
  // panel side: beats latched when the write strobe negates
  // ==========
  int rd_idx;

  always @(posedge ctl.panel_write_strobe_n or posedge clr) begin
    if (clr) begin
      wr_cnt <= 0;
    end else begin
      wr_log[wr_cnt[1:0]] <= {ctl.command_data_select, data_lvl};
      wr_cnt <= wr_cnt + 1;
    end
  end

  // drives only while its read strobe is low, then lets go at once
  always @(posedge ctl.panel_read_strobe_n or posedge clr) begin
    if (clr) begin
      rd_idx <= 0;
    end else begin
      rd_idx <= rd_idx + 1;
    end
  end
  assign drv_en = !ctl.panel_read_strobe_n;
  assign drv_val = rd_beats[16 * rd_idx[1:0] +: 16];
endmodule

// file: testbench/ppb_ctrl_tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin miscompares++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module ppb_ctrl_tb;
  import ppb_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0, clr = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, drv_en;
  logic [15:0] pins_out, pins_oe_n, pins_pull, drv_val, last_q, pins;
  logic [15:0] gp_en = 16'h0, gp_val = 16'h0;
  logic [3:0] ctl_oe_n, irq_drv = 4'hf;
  logic [5:0] ext_irq_lines;
  logic [63:0] rd_beats = 64'h9abc_def0_1357_2468;
  logic [3:0][16:0] wr_log;
  ppb_ctl_t ctl_out, ctl_lvl;
  int wr_cnt, miscompares = 0, samples_checked = 0;

  always #20 hclk = ~hclk;
  // a released line shows its pull-up, or else the inverse of its last level
  assign pins = (pins_out & ~pins_oe_n) | (pins_oe_n & (drv_en ? drv_val
    : ((gp_en & gp_val) | (~gp_en & (pins_pull | ~last_q)))));
  assign ctl_lvl = (ctl_out & ~ctl_oe_n) | (irq_drv & ctl_oe_n);
  always @(posedge hclk) last_q <= pins;

  ppb_ctrl DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .panel_data_pins_in(pins), .panel_data_pins_out(pins_out),
    .panel_data_pins_oe_n(pins_oe_n), .panel_data_pins_pull_up(pins_pull),
    .ctl_pins_in(ctl_lvl), .ctl_pins_out(ctl_out), .ctl_pins_oe_n(ctl_oe_n),
    .ext_irq_lines(ext_irq_lines));
  ppb_panel_model u_panel (.clr(clr), .ctl(ctl_lvl), .data_lvl(pins), .rd_beats(rd_beats),
    .drv_en(drv_en), .drv_val(drv_val), .wr_log(wr_log), .wr_cnt(wr_cnt));

  // ==========
  // bus master and scenarios
  // ==========
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
    {hsel, htrans, haddr, hwrite} <= {1'b1, 2'b10, a, w};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic t_regs;
    logic [31:0] r;
    logic [7:0] ofs [4] = '{OFS_PULL, OFS_FUNC, OFS_OUT, OFS_DIR};
    ahb(1'b0, OFS_TIMING, 0, r);
    `CHK(r, TIMING_RST)
    for (int i = 0; i < 4; i++) begin
      ahb(1'b0, ofs[i], 0, r);
      `CHK(r, 32'h0)
    end
    ahb(1'b1, 32'h04, 32'hffff_ffff, r);
    ahb(1'b0, 32'h04, 0, r);
    `CHK(r, 32'h0)
    ahb(1'b1, OFS_FUNC, 32'h0003_ffff, r);
    ahb(1'b0, OFS_FUNC, 0, r);
    `CHK(r, 32'h0003_0000)
    ahb(1'b1, OFS_TIMING, 32'hfffe_ffff, r); // port width kept at a legal code
    ahb(1'b0, OFS_TIMING, 0, r);
    `CHK(r, 32'h01fe_ffff)
    $display("test regs done");
  endtask

  // 16 bit big, 16 bit little with select off, then two 8 bit cases
  task automatic t_panel(input logic w);
    logic [31:0] tm [4] = '{32'h0102_0000, 32'h0006_f0f0, 32'h01fd_4321, 32'h0109_0f0f};
    logic [31:0] r, e;
    logic [31:0] d = 32'hcafe_f00d;
    logic wide;
    int n, pos;
    for (int k = 0; k < 4; k++) begin
      wide = (tm[k][17:16] == PW_16);
      n = wide ? 2 : 4;
      clr <= 1'b1;
      ahb(1'b1, OFS_TIMING, tm[k], r);
      clr <= 1'b0;
      ahb(1'b1, OFS_FUNC, 32'(k[0]) << FUNC_LITTLE_BIT, r);
      ahb(w, 32'h0010_0000, d, r);
      e = 32'h0;
      for (int i = 0; i < n; i++) begin
        pos = k[0] ? i : n - 1 - i;
        if (w && wide) `CHK(wr_log[i], ({i[0], d[16 * pos +: 16]}))
        else if (w) `CHK(wr_log[i][16:8], ({i[0], d[8 * pos +: 8]}))
        else if (wide) e[16 * pos +: 16] = rd_beats[16 * i +: 16];
        else e[8 * pos +: 8] = rd_beats[16 * i + 8 +: 8];
      end
      if (w) `CHK(wr_cnt, n)
      else `CHK(r, e)
    end
    $display("test panel write=%0d done", w);
  endtask

  task automatic t_gpio;
    logic [31:0] r;
    gp_en <= 16'h000f;
    gp_val <= 16'h0009;
    ahb(1'b1, OFS_DIR, 32'h0000_ff00, r);
    ahb(1'b1, OFS_OUT, 32'h0000_a5c3, r);
    ahb(1'b1, OFS_PULL, 32'h0000_00f0, r);
    ahb(1'b1, OFS_FUNC, 32'h0006_0000, r);
    ahb(1'b1, OFS_IN, 32'h0, r);
    ahb(1'b0, OFS_IN, 0, r);
    `CHK(r[15:0], 16'ha5f9)
    `CHK(pins_out[15:8], 8'ha5)
    `CHK(pins_oe_n, 16'h00ff)
    `CHK(pins_pull, 16'h00f0)
    ahb(1'b1, OFS_FUNC, 32'h0, r);
    gp_en <= 16'h0;
    $display("test gpio done");
  endtask

  task automatic t_irq;
    logic [31:0] r;
    logic [5:0] e;
    ahb(1'b1, OFS_FUNC, 32'h0008_0000, r);
    repeat (2) @(posedge hclk);
    for (int p = 0; p < 16; p++) begin
      irq_drv <= p[3:0];
      e = {p[3], p[2], 1'b0, p[1], p[0], 1'b0};
      repeat (2) @(negedge hclk);
      `CHK(ext_irq_lines, e)
      @(posedge hclk);
    end
    `CHK(ctl_oe_n, 4'hf)
    ahb(1'b1, OFS_FUNC, 32'h0, r);
    $display("test irq done");
  endtask

  task report_and_stop;
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_panel(1'b1);
    t_panel(1'b0);
    t_gpio;
    t_irq;
    report_and_stop;
  end

  // the whole run needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge hclk);
    miscompares++;
    report_and_stop;
  end
endmodule
